//--- core/tlcc_pkg.sv
// Constants for the transmit link clock control register bank
package tlcc_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NLINK = 16;
   localparam int NREF = 4;
   localparam int NPLL = 2;
   localparam int NMON = 2 * NLINK + NREF;
   localparam int MON_RX_BASE = 0;
   localparam int MON_TX_BASE = NLINK;
   localparam int MON_REF_BASE = 2 * NLINK;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // ----------------------------------------------------------------
   // Register map (word addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_BASE = 16'h0600;
   localparam logic [15:0] MAP_LO_BASE = 16'h0610;
   localparam logic [15:0] MAP_HI_BASE = 16'h0620;
   localparam logic [15:0] TX_FLT_ADDR = 16'h0630;
   localparam logic [15:0] RX_FLT_ADDR = 16'h0631;
   localparam logic [15:0] REF_FLT_ADDR = 16'h0632;
   localparam logic [15:0] PLL_BASE = 16'h0634;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h7fff;
   localparam logic [15:0] PLL_WMASK = 16'h001f;
   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int B_SRC_LO = 10;
   localparam int SRC_W = 5;
   localparam int B_DIR = 9;
   localparam int B_LOOP = 8;
   localparam int B_EN = 7;
   localparam int B_RATE_LO = 5;
   localparam int B_POL = 1;
   localparam logic [4:0] SRC_REF_BASE = 5'h10;
   localparam logic [4:0] SRC_REF_END = 5'h14;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int FAULT_WINDOW_NS = 2000;
   localparam int FAULT_WINDOW_CYC = (FAULT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- core/tlcc_mon_if.sv
// Carrier of filtered clock levels, edges and fault flags
`timescale 1ns/1ps
`default_nettype none
interface tlcc_mon_if #(parameter int N = 36);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   logic [N-1:0] fault;
   modport mon (output level, output rise, output fall, output fault);
   modport use_side (input level, input rise, input fall, input fault);
endinterface
`default_nettype wire

//--- core/tlcc_clk_mon.sv
// Clock synchroniser, edge finder and missing-edge fault monitor
`timescale 1ns/1ps
`default_nettype none
module tlcc_clk_mon
   import tlcc_pkg::*;
#(
   parameter int N = NMON,
   parameter int WINDOW = FAULT_WINDOW_CYC
) (
   input wire logic i_ref_clk, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic [N-1:0] i_pins, // Raw clock pins
   tlcc_mon_if.mon mon // Filtered view out
);
   localparam int CW = $clog2(WINDOW + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(WINDOW - 1);

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] level;
      logic [N-1:0] rise;
      logic [N-1:0] fall;
      logic [N-1:0] fault;
      logic [N-1:0][CW-1:0] cnt;
   } tlcc_mon_s;

   tlcc_mon_s q, next_q;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // First stage feeds only the second; decisions use stages two and three
   always_comb begin
      next_q = q;
      next_q.s1 = i_pins;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.rise = '0;
      next_q.fall = '0;
      for (int i = 0; i < N; i++) begin
         // A change counts only once stages two and three agree
         if (q.s2[i] == q.s3[i] && q.s3[i] != q.level[i]) begin
            next_q.level[i] = q.s3[i];
            next_q.rise[i] = q.s3[i];
            next_q.fall[i] = ~q.s3[i];
         end
         if (q.s2[i] == q.s3[i] && q.s3[i] != q.level[i]) begin
            next_q.cnt[i] = '0;
            next_q.fault[i] = 1'b0;
         end else if (q.cnt[i] >= CNT_LAST) begin
            next_q.fault[i] = 1'b1;
         end else begin
            next_q.cnt[i] = q.cnt[i] + CW'(1);
         end
      end
   end

   // Register stage
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign mon.level = q.level;
   assign mon.rise = q.rise;
   assign mon.fall = q.fall;
   assign mon.fault = q.fault;
endmodule
`default_nettype wire

//--- core/tlcc_top.sv
// Transmit link clock control register bank with clock health monitors
// How it works
// - sixteen per-link control words reset to zero
// - bit 9 picks clock direction, output or input
// - bit 8 loops receive pins to transmit
// - bit 7 clear floats the transmit port
// - bits 6:5 hold the link rate code
// - bit 1 picks launch edge, falling or rising
// - transmit clock fault flags, one per link
// - receive clock fault flags, one per link
// - four reference clock faults, upper bits zero
// - five-bit code selects the PLL reference
// - two PLL selects, upper bits read zero
// - bits 14:10 pick the output clock source
`timescale 1ns/1ps
`default_nettype none
module tlcc_top
   import tlcc_pkg::*;
(
   input wire logic i_ref_clk, // System clock, 20 MHz
   input wire logic i_resetn, // Async reset, active low
   input wire logic [ADDR_W-1:0] i_addr, // Register word address
   input wire logic i_wr, // Write strobe, one cycle
   input wire logic i_rd, // Read strobe, one cycle
   input wire logic [DATA_W-1:0] i_wdata, // Write data
   output logic [DATA_W-1:0] o_rdata, // Read data, one cycle after i_rd
   input wire logic [NLINK-1:0] i_tx_line_clock, // Transmit clock pin level
   output logic [NLINK-1:0] o_tx_line_clock, // Transmit clock drive value
   output logic [NLINK-1:0] o_tx_line_clock_oe, // Transmit clock drive enable
   input wire logic [NLINK-1:0] i_rx_line_clock, // Receive clock pins
   input wire logic [NLINK-1:0] i_rx_line_data, // Receive data pins
   input wire logic [NLINK-1:0] i_tx_data, // Bits to send from the core
   output logic [NLINK-1:0] o_serial_tx_line, // Transmit data value
   output logic [NLINK-1:0] o_serial_tx_line_oe, // Transmit data drive enable
   input wire logic [NREF-1:0] i_reference_clock_input, // Reference clocks
   output logic [NPLL-1:0] o_pll_reference_output // PLL reference outputs
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NLINK-1:0][DATA_W-1:0] ctrl;
      logic [NLINK-1:0][DATA_W-1:0] map_lo;
      logic [NLINK-1:0][DATA_W-1:0] map_hi;
      logic [NPLL-1:0][SRC_W-1:0] pll_sel;
      logic [DATA_W-1:0] rdata;
      logic [NLINK-1:0] rxd1;
      logic [NLINK-1:0] rxd2;
      logic [NLINK-1:0] rxd3;
      logic [NLINK-1:0] tx_line_clock;
      logic [NLINK-1:0] tx_line_clock_oe;
      logic [NLINK-1:0] txd;
      logic [NLINK-1:0] txd_oe;
      logic [NPLL-1:0] pll_out;
   } tlcc_top_s;

   tlcc_top_s q, next_q;

   // ----------------------------------------------------------------
   // Clock monitors: receive, transmit, reference in one bank
   // ----------------------------------------------------------------
   tlcc_mon_if #(.N(NMON)) mon_bus ();

   tlcc_clk_mon #(.N(NMON), .WINDOW(FAULT_WINDOW_CYC)) u_mon (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_pins({i_reference_clock_input, i_tx_line_clock, i_rx_line_clock}),
      .mon(mon_bus.mon)
   );

   logic [NLINK-1:0] rx_lvl, rx_rise, rx_fall, tx_lvl, tx_rise, tx_fall;
   logic [NREF-1:0] ref_lvl, ref_rise, ref_fall;

   // Split the monitor bank back into its three groups
   assign rx_lvl = mon_bus.level[MON_RX_BASE +: NLINK];
   assign rx_rise = mon_bus.rise[MON_RX_BASE +: NLINK];
   assign rx_fall = mon_bus.fall[MON_RX_BASE +: NLINK];
   assign tx_lvl = mon_bus.level[MON_TX_BASE +: NLINK];
   assign tx_rise = mon_bus.rise[MON_TX_BASE +: NLINK];
   assign tx_fall = mon_bus.fall[MON_TX_BASE +: NLINK];
   assign ref_lvl = mon_bus.level[MON_REF_BASE +: NREF];
   assign ref_rise = mon_bus.rise[MON_REF_BASE +: NREF];
   assign ref_fall = mon_bus.fall[MON_REF_BASE +: NREF];

   // ----------------------------------------------------------------
   // Clock source decode, shared by link clocks and PLL references
   // ----------------------------------------------------------------
   // Codes 0-15 pick a receive clock, 16-19 a reference clock, others hold low
   function automatic logic tlcc_pick(input logic [SRC_W-1:0] code,
                                      input logic [NLINK-1:0] rx,
                                      input logic [NREF-1:0] rf);
      logic r;
      r = 1'b0;
      if (code < SRC_REF_BASE) begin
         r = rx[code[3:0]];
      end else if (code < SRC_REF_END) begin
         r = rf[code[1:0]];
      end
      return r;
   endfunction

   // True when the address lies in the sixteen-word block of base
   function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
      return a[ADDR_W-1:4] == base[ADDR_W-1:4];
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [SRC_W-1:0] src;
      logic dir_in, loop, pol, eff_lvl, eff_rise, eff_fall, edge_hit, din;
      logic [3:0] idx;
      logic [DATA_W-1:0] rd;
      src = '0;
      dir_in = 1'b0;
      loop = 1'b0;
      pol = 1'b0;
      eff_lvl = 1'b0;
      eff_rise = 1'b0;
      eff_fall = 1'b0;
      edge_hit = 1'b0;
      din = 1'b0;
      idx = i_addr[3:0];
      rd = '0;
      next_q = q;

      // Receive data pins pass three stages before loopback uses them
      next_q.rxd1 = i_rx_line_data;
      next_q.rxd2 = q.rxd1;
      next_q.rxd3 = q.rxd2;

      // Register writes; reserved-bit values are software's duty
      // stored as written, except control bit 15 and PLL select bits 15:5, which are dropped
      if (i_wr) begin
         if (in_block(i_addr, CTRL_BASE)) begin
            // rate code kept in the control word
            next_q.ctrl[idx] = i_wdata & CTRL_WMASK;
         end else if (in_block(i_addr, MAP_LO_BASE)) begin
            next_q.map_lo[idx] = i_wdata;
         end else if (in_block(i_addr, MAP_HI_BASE)) begin
            next_q.map_hi[idx] = i_wdata;
         end else if (i_addr == PLL_BASE || i_addr == PLL_BASE + 16'h0001) begin
            // only the low five bits are held
            next_q.pll_sel[i_addr[0]] = i_wdata[SRC_W-1:0];
         end
      end

      // Register reads, registered; unmapped words return zero
      if (i_rd) begin
         if (in_block(i_addr, CTRL_BASE)) begin
            rd = q.ctrl[idx];
         end else if (in_block(i_addr, MAP_LO_BASE)) begin
            rd = q.map_lo[idx];
         end else if (in_block(i_addr, MAP_HI_BASE)) begin
            rd = q.map_hi[idx];
         end else if (i_addr == TX_FLT_ADDR) begin
            rd = mon_bus.fault[MON_TX_BASE +: NLINK];
         end else if (i_addr == RX_FLT_ADDR) begin
            rd = mon_bus.fault[MON_RX_BASE +: NLINK];
         end else if (i_addr == REF_FLT_ADDR) begin
            rd = {12'h000, mon_bus.fault[MON_REF_BASE +: NREF]};
         end else if (i_addr == PLL_BASE || i_addr == PLL_BASE + 16'h0001) begin
            rd = {11'h000, q.pll_sel[i_addr[0]]};
         end
         next_q.rdata = rd;
      end

      // Per-link transmit clock and data
      for (int n = 0; n < NLINK; n++) begin
         src = q.ctrl[n][B_SRC_LO +: SRC_W];
         dir_in = q.ctrl[n][B_DIR];
         loop = q.ctrl[n][B_LOOP];
         pol = q.ctrl[n][B_POL];
         // loopback takes clock and data from receive pins
         if (loop) begin
            eff_lvl = rx_lvl[n];
            eff_rise = rx_rise[n];
            eff_fall = rx_fall[n];
            din = q.rxd3[n];
         end else if (dir_in) begin
            eff_lvl = tx_lvl[n];
            eff_rise = tx_rise[n];
            eff_fall = tx_fall[n];
            din = i_tx_data[n];
         // output clock from the selected source
         end else begin
            eff_lvl = tlcc_pick(src, rx_lvl, ref_lvl);
            eff_rise = tlcc_pick(src, rx_rise, ref_rise);
            eff_fall = tlcc_pick(src, rx_fall, ref_fall);
            din = i_tx_data[n];
         end
         // disabled link floats clock and data
         next_q.txd_oe[n] = q.ctrl[n][B_EN];
         next_q.tx_line_clock_oe[n] = q.ctrl[n][B_EN] & (~dir_in | loop);
         next_q.tx_line_clock[n] = eff_lvl;
         // launch on falling edge unless polarity set
         edge_hit = pol ? eff_rise : eff_fall;
         if (edge_hit) begin
            next_q.txd[n] = din;
         end
      end

      // PLL reference follows its select code
      for (int p = 0; p < NPLL; p++) begin
         next_q.pll_out[p] = tlcc_pick(q.pll_sel[p], rx_lvl, ref_lvl);
      end
   end

   // ----------------------------------------------------------------
   // Register stage
   // ----------------------------------------------------------------
   // everything, control words included, clears on reset
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Outputs come straight from the state flops
   assign o_rdata = q.rdata;
   assign o_tx_line_clock = q.tx_line_clock;
   assign o_tx_line_clock_oe = q.tx_line_clock_oe;
   assign o_serial_tx_line = q.txd;
   assign o_serial_tx_line_oe = q.txd_oe;
   assign o_pll_reference_output = q.pll_out;
endmodule
`default_nettype wire

//--- dv/tlcc_monitor.sv
// Port-level assertions for the transmit link clock control bank
`timescale 1ns/1ps
`default_nettype none
module tlcc_monitor
   import tlcc_pkg::*;
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_resetn, // Reset, active low
   input wire logic [ADDR_W-1:0] i_addr, // Address
   input wire logic i_wr, // Write
   input wire logic i_rd, // Read
   input wire logic [DATA_W-1:0] i_wdata, // Write data
   input wire logic [DATA_W-1:0] o_rdata, // Read data
   input wire logic [NLINK-1:0] o_tx_line_clock_oe, // Clock enable
   input wire logic [NLINK-1:0] o_serial_tx_line_oe, // Data enable
   input wire logic [NPLL-1:0] o_pll_reference_output // PLL outputs
);
   // -------------------------------------------------------------
   // Shadow of the written control bits
   // -------------------------------------------------------------
   logic [NLINK-1:0] en, dir, lp;
   logic [4:0] pll0;
   logic [2:0] quiet;
   wire logic is_ctrl;
   assign is_ctrl = (i_addr[15:4] == CTRL_BASE[15:4]);
   // Quiet counts idle cycles so outputs are judged only once settled
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         en <= '0;
         dir <= '0;
         lp <= '0;
         pll0 <= '0;
         quiet <= '0;
      end else begin
         quiet <= i_wr ? 3'h0 : quiet + {2'h0, ~&quiet};
         if (i_wr && is_ctrl) begin
            en[i_addr[3:0]] <= i_wdata[7];
            dir[i_addr[3:0]] <= i_wdata[9];
            lp[i_addr[3:0]] <= i_wdata[8];
         end
         if (i_wr && i_addr == PLL_BASE) begin
            pll0 <= i_wdata[4:0];
         end
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence read_at(logic [15:0] a);
      i_rd && i_addr == a;
   endsequence
   sequence settled;
      quiet > 3'h3;
   endsequence
   a_ctrl_top_zero: assert property (i_rd && is_ctrl |=> !o_rdata[15])
      else $error("control bit 15 read back set");
   a_ref_upper_zero: assert property (read_at(REF_FLT_ADDR) |=> o_rdata[15:4] == 12'h000)
      else $error("reference status upper bits set");
   a_unmapped_zero: assert property (read_at(16'h0633) |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_pll_readback: assert property (read_at(PLL_BASE) |=> o_rdata == {11'h000, $past(pll0)})
      else $error("PLL select readback wrong");
   a_port_float: assert property (settled |-> o_serial_tx_line_oe == en)
      else $error("data enable differs from link enable");
   a_clk_input_float: assert property (settled |-> (o_tx_line_clock_oe & ~(en & (~dir | lp))) == '0)
      else $error("clock driven while input or disabled");
   a_clk_output_drive: assert property (settled |-> (o_tx_line_clock_oe & en & ~dir) == (en & ~dir))
      else $error("clock not driven in output mode");
   a_pll_const_low: assert property (settled and pll0 > 5'h13 |-> !o_pll_reference_output[0])
      else $error("PLL output moves on a constant code");
endmodule
`default_nettype wire

//--- dv/tlcc_xdsl_model.sv
// Far-end transceiver model: line clocks, line data, transmit clock wire
`timescale 1ns/1ps
`default_nettype none
module tlcc_xdsl_model
   import tlcc_pkg::*;
(
   input wire logic [NLINK-1:0] i_run_rx, // Receive clocks run
   input wire logic [NLINK-1:0] i_run_tx, // Far transmit clocks run
   input wire logic [NREF-1:0] i_run_ref, // Reference clocks run
   input wire logic [NLINK-1:0] i_drive, // Device clock value
   input wire logic [NLINK-1:0] i_drive_oe, // Device clock enable
   output logic [NLINK-1:0] o_rx_clk, // Receive clocks
   output logic [NLINK-1:0] o_rx_data, // Receive data
   output logic [NREF-1:0] o_ref_clk, // Reference clocks
   output logic [NLINK-1:0] o_tx_wire // Resolved clock wire
);
   // -------------------------------------------------------------
   // Free 400 ns link clock, phase unrelated to the system clock
   // -------------------------------------------------------------
   // Set at declaration so no level event fires at time zero before the outputs are cleared
   logic lc = 1'b0;
   logic [NLINK-1:0] ext;
   initial begin
      #137;
      forever #200 lc = ~lc;
   end
   // A stopped clock stands still at its last level
   always @(lc) begin
      o_rx_clk <= (o_rx_clk & ~i_run_rx) | ({NLINK{lc}} & i_run_rx);
      o_ref_clk <= (o_ref_clk & ~i_run_ref) | ({NREF{lc}} & i_run_ref);
      ext <= (ext & ~i_run_tx) | ({NLINK{lc}} & i_run_tx);
      o_rx_data <= {o_rx_data[NLINK-2:0], ~o_rx_data[NLINK-1]};
   end
   initial begin
      o_rx_clk = '0;
      o_ref_clk = '0;
      ext = '0;
      o_rx_data = '0;
   end
   // wire follows the device only while it drives
   assign o_tx_wire = (i_drive & i_drive_oe) | (ext & ~i_drive_oe);
endmodule
`default_nettype wire

//--- dv/test_tdm_tx_link_clock_control.sv
// Self-checking bench for the transmit link clock control bank
`timescale 1ns/1ps
`default_nettype none
module test_tdm_tx_link_clock_control
   import tlcc_pkg::*;
;
   logic i_ref_clk, i_resetn, i_wr, i_rd;
   logic [15:0] i_addr, i_wdata, i_tx_data, run_rx, run_tx;
   logic [3:0] run_ref;
   wire logic [15:0] o_rdata, o_tx_line_clock, o_tx_line_clock_oe, o_serial_tx_line;
   wire logic [15:0] o_serial_tx_line_oe, tx_wire, rx_clk, rx_data;
   wire logic [3:0] ref_clk;
   wire logic [1:0] pll_out;
   wire logic [17:0] obs_clk, obs_dat;
   int num_errors, tests_run;
   // -------------------------------------------------------------
   // Clock, stimulus and instances
   // -------------------------------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // Core data walks a slow ring; a per-cycle toggle would repeat every 8-cycle link period
   always @(posedge i_ref_clk) i_tx_data <= {i_tx_data[14:0], ~i_tx_data[15]};
   assign obs_clk = {pll_out, o_tx_line_clock};
   assign obs_dat = {2'b00, o_serial_tx_line};
   tlcc_top i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_tx_line_clock(tx_wire),
      .o_tx_line_clock(o_tx_line_clock), .o_tx_line_clock_oe(o_tx_line_clock_oe),
      .i_rx_line_clock(rx_clk), .i_rx_line_data(rx_data), .i_tx_data(i_tx_data),
      .o_serial_tx_line(o_serial_tx_line), .o_serial_tx_line_oe(o_serial_tx_line_oe),
      .i_reference_clock_input(ref_clk), .o_pll_reference_output(pll_out));
   tlcc_xdsl_model i_far (.i_run_rx(run_rx), .i_run_tx(run_tx), .i_run_ref(run_ref),
      .i_drive(o_tx_line_clock), .i_drive_oe(o_tx_line_clock_oe), .o_rx_clk(rx_clk),
      .o_rx_data(rx_data), .o_ref_clk(ref_clk), .o_tx_wire(tx_wire));
   task automatic finish_test();
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   // Read answer lands one edge after the strobe is taken
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(posedge i_ref_clk);
      #1 chk(o_rdata, exp);
   endtask
   // Writes a word, then counts wanted clock edges and stray data moves
   task automatic clk_case(input logic [15:0] a, input logic [15:0] d, input int lk,
         input logic pol, input logic live);
      logic pc, pd, c, w;
      int edg;
      int bad;
      wr(a, d);
      edg = 0;
      bad = 0;
      repeat (8) @(posedge i_ref_clk);
      #1 pc = obs_clk[lk];
      pd = obs_dat[lk];
      repeat (64) begin
         @(posedge i_ref_clk);
         #1 c = obs_clk[lk];
         w = pol ? (!pc && c) : (pc && !c);
         edg += int'(w);
         bad += int'(obs_dat[lk] !== pd && !w);
         pc = c;
         pd = obs_dat[lk];
      end
      chk(16'(edg > 0), 16'(live));
      chk(16'(bad), 16'h0000);
   endtask
   task automatic t_regs();
      logic [1:0] rt;
      rd(RX_FLT_ADDR, REG_RESET);
      rd(PLL_BASE, REG_RESET);
      for (int n = 0; n < 16; n++) begin
         rt = (n % 4 == 0) ? 2'h3 : ((n % 2 == 0) ? 2'h2 : 2'h1);
         rd(CTRL_BASE + 16'(n), REG_RESET);
         rd(MAP_HI_BASE + 16'(n), REG_RESET);
         wr(CTRL_BASE + 16'(n), {9'h000, rt, 5'h01});
         rd(CTRL_BASE + 16'(n), {9'h000, rt, 5'h01});
         wr(MAP_LO_BASE + 16'(n), 16'hffff);
         rd(MAP_LO_BASE + 16'(n), 16'hffff);
      end
      wr(CTRL_BASE + 16'h000f, 16'hffff);
      rd(CTRL_BASE + 16'h000f, 16'h7fff);
      wr(PLL_BASE + 16'h0001, 16'hffff);
      rd(PLL_BASE + 16'h0001, 16'h001f);
      wr(TX_FLT_ADDR, 16'hffff);
      rd(TX_FLT_ADDR, REG_RESET);
      wr(16'h0633, 16'hffff);
      rd(16'h0633, REG_RESET);
   endtask
   task automatic t_faults();
      run_rx <= 16'hfff7;
      run_tx <= 16'hffdf;
      run_ref <= 4'hb;
      repeat (60) @(posedge i_ref_clk);
      rd(TX_FLT_ADDR, 16'h0020);
      rd(RX_FLT_ADDR, 16'h0008);
      rd(REF_FLT_ADDR, 16'h0004);
      run_rx <= '1;
      run_tx <= '1;
      run_ref <= '1;
      repeat (60) @(posedge i_ref_clk);
      rd(TX_FLT_ADDR, 16'h0000);
      rd(RX_FLT_ADDR, 16'h0000);
      rd(REF_FLT_ADDR, 16'h0000);
   endtask
   task automatic t_links();
      clk_case(CTRL_BASE, 16'h00a1, 0, 1'b0, 1'b1);
      clk_case(CTRL_BASE, 16'h00a3, 0, 1'b1, 1'b1);
      clk_case(CTRL_BASE, 16'h50a1, 0, 1'b0, 1'b0);
      run_tx <= 16'hfffd;
      clk_case(CTRL_BASE + 16'h0001, 16'h03a1, 1, 1'b0, 1'b1);
      clk_case(CTRL_BASE + 16'h0001, 16'h02a1, 1, 1'b0, 1'b0);
      run_tx <= '1;
      clk_case(PLL_BASE, 16'h0010, 16, 1'b0, 1'b1);
      clk_case(PLL_BASE + 16'h0001, 16'h0000, 17, 1'b0, 1'b1);
      clk_case(PLL_BASE, 16'h0014, 16, 1'b0, 1'b0);
   endtask
   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      i_resetn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_tx_data = '0;
      run_rx = '1;
      run_tx = '1;
      run_ref = '1;
      num_errors = 0;
      tests_run = 0;
      repeat (16) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_faults();
      t_links();
      finish_test();
   end
   // Whole run is about a thousand cycles; this cuts a hang short
   initial begin
      #1000000;
      num_errors++;
      finish_test();
   end
endmodule
bind tlcc_top tlcc_monitor i_mon (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_tx_line_clock_oe(o_tx_line_clock_oe), .o_serial_tx_line_oe(o_serial_tx_line_oe),
   .o_pll_reference_output(o_pll_reference_output));
`default_nettype wire
